// [src/led_dim_params.svh]
// Register offsets, field positions, reset values and timing counts of the LED dimming control.
`ifndef LED_DIM_PARAMS_SVH
`define LED_DIM_PARAMS_SVH
`define ADDR_DIMMING_CONTROL 8'h15
`define ADDR_RAMP_TIMING 8'h16
`define ADDR_CHANNEL_TRIGGER 8'h17
`define CTRL_SRC_BIT 0
`define CTRL_SHAPE_BIT 1
`define TIMING_RISE_MSB 7
`define TIMING_RISE_LSB 4
`define TIMING_FALL_MSB 3
`define TIMING_FALL_LSB 0
`define TRIG_RAMP_BIT 4
`define RESET_DIMMING_CONTROL 2'h0
`define RESET_RAMP_CODE 4'h8
`define RESET_RAMP_ENABLE 1'h0
`define RESET_TARGETS 4'h0
`define LEVEL_FULL 8'hFF
`define LEVEL_STEPS 255
`define CLK_PERIOD_NS 50
`define NS_PER_MS 1000000
`define CYCLES_PER_MS (`NS_PER_MS / `CLK_PERIOD_NS)
`endif

// [src/led_dim_pkg.sv]
// Types shared by the LED dimming control.
package led_dim_pkg;
  // Dimming control register contents, low two bits only.
  typedef struct packed {
    logic linear;  // Ramp curve: 0 logarithmic, 1 linear.
    logic ext_src; // Dimming source: 0 internal generator, 1 auxiliary pin.
  } dim_ctrl_t;
  // Ramp timing register contents.
  typedef struct packed {
    logic [3:0] rise;
    logic [3:0] fall;
  } ramp_timing_t;
  // Register port request.
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;
endpackage : led_dim_pkg

// [src/led_pwm_dimming_control.sv]
// PWM dimming control for four LED current outputs with shared rise and fall ramps.
`timescale 1ns/100ps
`include "led_dim_params.svh"

module led_pwm_dimming_control #(
  parameter int unsigned CYCLES_PER_MS = `CYCLES_PER_MS
) (
  input wire logic clk_in,                     // System clock, 20 MHz.
  input wire logic arst_n_in,                  // Asynchronous reset, active low.
  input wire led_dim_pkg::reg_req_t reg_req_in, // Register read or write request.
  input wire logic [3:0] channel_mode_pwm_in,  // Per channel: mode setting selects PWM.
  input wire logic aux_pwm_in,                 // Auxiliary pin, external PWM waveform.
  output logic [7:0] rd_data_out,              // Read data, valid the cycle after a read.
  output logic [3:0] current_output_out        // Gate of current_output_a to _d.
);

  // ----------------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------------

  // Ramp duration in milliseconds for a nonzero code.
  function automatic int unsigned ramp_ms(input logic [3:0] code);
    int unsigned ms;
    ms = 0;
    unique case (code)
      4'h1: ms = 120;
      4'h2: ms = 250;
      4'h3: ms = 380;
      4'h4: ms = 510;
      4'h5: ms = 770;
      4'h6: ms = 1000;
      4'h7: ms = 1600;
      4'h8: ms = 2100;
      4'h9: ms = 2600;
      4'hA: ms = 3100;
      4'hB: ms = 4200;
      4'hC: ms = 5200;
      4'hD: ms = 6200;
      4'hE: ms = 7300;
      4'hF: ms = 8300;
      default: ms = 0;
    endcase
    return ms;
  endfunction : ramp_ms

  // Cycles between level steps, minus one, so a full linear sweep lasts the coded time.
  function automatic logic [23:0] step_reload(input logic [3:0] code);
    int unsigned cyc;
    cyc = (ramp_ms(code) * CYCLES_PER_MS) / `LEVEL_STEPS;
    if (cyc < 1)
    begin
      cyc = 1;
    end
    return 24'(cyc - 1);
  endfunction : step_reload

  // One brightness step; the logarithmic curve steps in proportion to the level.
  function automatic logic [7:0] ramp_step(input logic [7:0] lvl, input logic up, input logic linear);
    logic [8:0] inc;
    logic [8:0] res;
    inc = linear ? 9'h001 : 9'({4'h0, lvl[7:4]} + 8'h01);
    res = 9'h000;
    if (up)
    begin
      res = {1'b0, lvl} + inc;
      if (res > {1'b0, `LEVEL_FULL})
      begin
        res = {1'b0, `LEVEL_FULL};
      end
    end
    else
    begin
      res = ({1'b0, lvl} > inc) ? ({1'b0, lvl} - inc) : 9'h000;
    end
    return res[7:0];
  endfunction : ramp_step

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------

  led_dim_pkg::dim_ctrl_t ctrl;
  led_dim_pkg::ramp_timing_t timing;
  logic ramp_en;
  logic [3:0] target;
  logic aux_meta;
  logic aux_sync;
  logic [7:0] pwm_cnt;
  logic [23:0] rise_cnt;
  logic [23:0] fall_cnt;
  logic tick_rise;
  logic tick_fall;
  logic [7:0] level [4];
  logic [3:0] status;

  // Writes from the register port; the channel bits store targets only.
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      ctrl <= `RESET_DIMMING_CONTROL;
      timing <= {`RESET_RAMP_CODE, `RESET_RAMP_CODE};
      ramp_en <= `RESET_RAMP_ENABLE;
      target <= `RESET_TARGETS;
    end
    else if (reg_req_in.wr)
    begin
      unique case (reg_req_in.addr)
        `ADDR_DIMMING_CONTROL:
        begin
          ctrl.linear <= reg_req_in.wdata[`CTRL_SHAPE_BIT];
          ctrl.ext_src <= reg_req_in.wdata[`CTRL_SRC_BIT];
        end
        `ADDR_RAMP_TIMING:
        begin
          timing.rise <= reg_req_in.wdata[`TIMING_RISE_MSB:`TIMING_RISE_LSB];
          timing.fall <= reg_req_in.wdata[`TIMING_FALL_MSB:`TIMING_FALL_LSB];
        end
        `ADDR_CHANNEL_TRIGGER:
        begin
          ramp_en <= reg_req_in.wdata[`TRIG_RAMP_BIT];
          target <= reg_req_in.wdata[3:0];
        end
        default:
        begin
        end
      endcase
    end
  end

  // Reads return the live status, not the written targets; unmapped reads give zero.
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      rd_data_out <= 8'h00;
    end
    else if (reg_req_in.rd)
    begin
      unique case (reg_req_in.addr)
        `ADDR_DIMMING_CONTROL: rd_data_out <= {6'h00, ctrl};
        `ADDR_RAMP_TIMING: rd_data_out <= timing;
        `ADDR_CHANNEL_TRIGGER: rd_data_out <= {3'h0, ramp_en, status};
        default: rd_data_out <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Auxiliary pin synchroniser and internal PWM counter
  // ----------------------------------------------------------------------

  // The pin is asynchronous; only aux_sync is read by logic.
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      aux_meta <= 1'b0;
      aux_sync <= 1'b0;
    end
    else
    begin
      aux_meta <= aux_pwm_in;
      aux_sync <= aux_meta;
    end
  end

  // Free-running 8-bit PWM period counter.
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      pwm_cnt <= 8'h00;
    end
    else
    begin
      pwm_cnt <= pwm_cnt + 8'h01;
    end
  end

  // ----------------------------------------------------------------------
  // Shared ramp step timers
  // ----------------------------------------------------------------------

  // One timer per direction serves every channel, so all ramps stay in step.
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      rise_cnt <= 24'h000000;
      fall_cnt <= 24'h000000;
      tick_rise <= 1'b0;
      tick_fall <= 1'b0;
    end
    else
    begin
      tick_rise <= (rise_cnt == 24'h000000);
      tick_fall <= (fall_cnt == 24'h000000);
      rise_cnt <= (rise_cnt == 24'h000000) ? step_reload(timing.rise) : rise_cnt - 24'h000001;
      fall_cnt <= (fall_cnt == 24'h000000) ? step_reload(timing.fall) : fall_cnt - 24'h000001;
    end
  end

  // ----------------------------------------------------------------------
  // Per-channel brightness and output gating
  // ----------------------------------------------------------------------

  // Level moves toward the target; outside PWM mode it is frozen and the target ignored.
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      for (int i = 0; i < 4; i++)
      begin
        level[i] <= 8'h00;
      end
    end
    else
    begin
      for (int i = 0; i < 4; i++)
      begin
        if (channel_mode_pwm_in[i])
        begin
          if (!ramp_en || (target[i] ? timing.rise : timing.fall) == 4'h0)
          begin
            level[i] <= target[i] ? `LEVEL_FULL : 8'h00;
          end
          else if (target[i] && level[i] != `LEVEL_FULL && tick_rise)
          begin
            level[i] <= ramp_step(level[i], 1'b1, ctrl.linear);
          end
          else if (!target[i] && level[i] != 8'h00 && tick_fall)
          begin
            level[i] <= ramp_step(level[i], 1'b0, ctrl.linear);
          end
        end
      end
    end
  end

  // Status and gated outputs; with the internal source, full level keeps the output on for the whole period.
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      status <= 4'h0;
      current_output_out <= 4'h0;
    end
    else
    begin
      for (int i = 0; i < 4; i++)
      begin
        status[i] <= channel_mode_pwm_in[i] && level[i] != 8'h00;
        current_output_out[i] <= channel_mode_pwm_in[i] && level[i] != 8'h00 &&
          (ctrl.ext_src ? aux_sync : (level[i] == `LEVEL_FULL || pwm_cnt < level[i]));
      end
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);

  a_linear_step: assert property (ctrl.linear && channel_mode_pwm_in[0] && ramp_en && target[0]
    && timing.rise != 4'h0 && tick_rise && level[0] < 8'hFE && $stable(target) && !reg_req_in.wr
    |=> level[0] == $past(level[0]) + 8'h01) else $error("linear ramp did not step by one");
  a_ext_gate_low: assert property (ctrl.ext_src && !aux_sync && !reg_req_in.wr
    |=> current_output_out == 4'h0) else $error("output on while external pwm low");
  a_timing_store: assert property (reg_req_in.wr && reg_req_in.addr == `ADDR_RAMP_TIMING
    |=> timing == $past(reg_req_in.wdata)) else $error("timing register not stored");
  a_rise_period: assert property (tick_rise && $stable(timing) && step_reload(timing.rise) != 24'h000000
    |=> rise_cnt == step_reload($past(timing.rise)) - 24'h000001) else $error("rise step period wrong");
  a_direct_switch: assert property (!ramp_en && channel_mode_pwm_in[0] && target[0]
    |=> level[0] == `LEVEL_FULL) else $error("direct switch did not turn full on");
  a_status_read: assert property (reg_req_in.rd && reg_req_in.addr == `ADDR_CHANNEL_TRIGGER
    |=> rd_data_out[3:0] == $past(status)) else $error("status read mismatch");
  a_target_write: assert property (reg_req_in.wr && reg_req_in.addr == `ADDR_CHANNEL_TRIGGER
    |=> target == $past(reg_req_in.wdata[3:0])) else $error("target not stored");
  a_mode_ignore: assert property (!channel_mode_pwm_in[1]
    |=> level[1] == $past(level[1]) && !current_output_out[1]) else $error("non pwm channel moved");
  a_sync_depth: assert property ($changed(aux_sync) |-> aux_sync == $past(aux_pwm_in, 2))
    else $error("aux pin not two stages deep");

  c_ramp_up: cover property (ramp_en && target[0] && tick_rise && level[0] == 8'hFE);
  c_ext_pwm: cover property (ctrl.ext_src && current_output_out[0] ##1 !current_output_out[0]);
  c_log_down: cover property (!ctrl.linear && ramp_en && !target[1] && tick_fall && level[1] != 8'h00);

endmodule : led_pwm_dimming_control

// [verification/led_dim_host_model.sv]
// Host model driving the register port and the auxiliary PWM pin of the dimming block.
`timescale 1ns/100ps
module led_dim_host_model (
  input wire logic clk_in,                   // System clock.
  input wire logic [7:0] rd_data_in,         // Read data from the block.
  output led_dim_pkg::reg_req_t reg_req_out, // Register request.
  output logic aux_pwm_out                   // External PWM waveform.
);
  // --------------------------------------------------------------
  // Register access
  // --------------------------------------------------------------
  // Idle address and data lines show the inverse of their last value and the strobes stay low, so stale data never looks valid.
  initial
  begin
    reg_req_out = '0;
    aux_pwm_out = 1'b0;
  end

  // One strobe, launched after an edge and held across the sampling edge.
  task automatic access(input logic [7:0] addr, input logic [7:0] data, input logic wr);
    @(posedge clk_in);
    #2;
    reg_req_out = '{addr, data, wr, ~wr};
    @(posedge clk_in);
    #2;
    reg_req_out = '{~addr, ~data, 1'b0, 1'b0};
  endtask : access

  task automatic write(input logic [7:0] addr, input logic [7:0] data);
    access(addr, data, 1'b1);
  endtask : write

  // Read data is taken one edge after the sampling edge, where it has settled.
  task automatic read(input logic [7:0] addr, output logic [7:0] data);
    access(addr, 8'h00, 1'b0);
    @(posedge clk_in);
    #2;
    data = rd_data_in;
  endtask : read

  // The pin level changes just after an edge, unrelated to any strobe.
  task automatic set_aux(input logic level);
    @(posedge clk_in);
    #2;
    aux_pwm_out = level;
  endtask : set_aux
endmodule : led_dim_host_model

// [verification/tb_led_pwm_dimming_control.sv]
// Self-checking testbench of the LED PWM dimming control.
`timescale 1ns/100ps
module tb_led_pwm_dimming_control;
  localparam int unsigned CPM = 2; // Shortened cycles per millisecond.
  localparam int LIN_FULL = 510 * CPM; // Linear rise of code 4 (0.51 s) in cycles.
  logic clk_in;
  logic arst_n_in;
  led_dim_pkg::reg_req_t reg_req;
  logic [3:0] mode_pwm;
  logic aux_pwm;
  logic [7:0] rd_data;
  logic [3:0] cur_out;
  logic [7:0] rv;
  logic [8:0] na;
  logic [8:0] nb;
  int err_count;
  int n_tests;

  led_pwm_dimming_control #(.CYCLES_PER_MS(CPM)) u_led_pwm_dimming_control (
    .clk_in(clk_in), .arst_n_in(arst_n_in), .reg_req_in(reg_req), .channel_mode_pwm_in(mode_pwm),
    .aux_pwm_in(aux_pwm), .rd_data_out(rd_data), .current_output_out(cur_out));
  led_dim_host_model u_led_dim_host_model (
    .clk_in(clk_in), .rd_data_in(rd_data), .reg_req_out(reg_req), .aux_pwm_out(aux_pwm));

  // --------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------
  initial
  begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end

  task automatic check(input string what, input logic [8:0] seen, input logic [8:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : check

  task automatic give_verdict();
    if (err_count == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict

  // Outputs change two edges after the write edge; the two-cycle wait covers that.
  task automatic settle_check(input logic [3:0] exp);
    repeat (2) @(posedge clk_in);
    #2;
    check("outputs", cur_out, exp);
  endtask : settle_check

  // Counts the on cycles of channels a and b over a whole PWM period.
  task automatic count_on();
    na = '0;
    nb = '0;
    repeat (256)
    begin
      @(posedge clk_in);
      #2;
      na = na + cur_out[0];
      nb = nb + cur_out[1];
    end
  endtask : count_on

  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task automatic t_reset_values();
    u_led_dim_host_model.read(8'h15, rv);
    check("control reset", rv, 8'h00);
    u_led_dim_host_model.read(8'h16, rv);
    check("timing reset", rv, 8'h88);
    u_led_dim_host_model.read(8'h20, rv);
    check("unmapped read", rv, 8'h00);
    u_led_dim_host_model.read(8'h17, rv);
    check("trigger reset", rv, 8'h00);
  endtask : t_reset_values

  task automatic t_reg_access();
    u_led_dim_host_model.write(8'h15, 8'hFF);
    u_led_dim_host_model.write(8'h16, 8'h5A);
    u_led_dim_host_model.read(8'h15, rv);
    check("control bits", rv, 8'h03);
    u_led_dim_host_model.read(8'h16, rv);
    check("timing fields", rv, 8'h5A);
    u_led_dim_host_model.write(8'h15, 8'h00);
  endtask : t_reg_access

  // Direct switching, then a channel whose mode is not PWM ignores its target.
  task automatic t_direct_and_mode();
    u_led_dim_host_model.write(8'h17, 8'h05);
    settle_check(4'h5);
    u_led_dim_host_model.read(8'h17, rv);
    check("status direct", rv, 8'h05);
    mode_pwm = 4'hD;
    u_led_dim_host_model.write(8'h17, 8'h0F);
    settle_check(4'hD);
    u_led_dim_host_model.read(8'h17, rv);
    check("status gated", rv, 8'h0D);
    mode_pwm = 4'hF;
    u_led_dim_host_model.write(8'h17, 8'h00);
    settle_check(4'h0);
  endtask : t_direct_and_mode

  // The pin must pass two flip-flops before it gates the outputs.
  task automatic t_external();
    u_led_dim_host_model.write(8'h15, 8'h01);
    u_led_dim_host_model.write(8'h17, 8'h0F);
    settle_check(4'h0);
    u_led_dim_host_model.set_aux(1'b1);
    repeat (2) @(posedge clk_in);
    #2;
    check("aux early", cur_out, 4'h0);
    @(posedge clk_in);
    #2;
    check("aux high", cur_out, 4'hF);
    u_led_dim_host_model.set_aux(1'b0);
    u_led_dim_host_model.write(8'h17, 8'h00);
    u_led_dim_host_model.write(8'h15, 8'h00);
  endtask : t_external

  // Rise code 4 and immediate fall; a logarithmic ramp ends well before a linear one.
  task automatic t_ramp(input logic [7:0] ctrl, input logic mid_full);
    u_led_dim_host_model.write(8'h15, ctrl);
    u_led_dim_host_model.write(8'h16, 8'h40);
    u_led_dim_host_model.write(8'h17, 8'h13);
    repeat (LIN_FULL / 2) @(posedge clk_in);
    u_led_dim_host_model.read(8'h17, rv);
    check("status ramp", rv, 8'h13);
    count_on();
    check("mid ramp full", 9'(na == 9'h100), 9'(mid_full));
    check("shared ramp", nb, na);
    repeat (LIN_FULL) @(posedge clk_in);
    count_on();
    check("ramp end", na, 9'h100);
    check("ramp end b", nb, 9'h100);
    u_led_dim_host_model.write(8'h17, 8'h10);
    settle_check(4'h0);
  endtask : t_ramp

  // --------------------------------------------------------------
  // Main sequence and watchdog
  // --------------------------------------------------------------
  initial
  begin
    err_count = 0;
    n_tests = 0;
    arst_n_in = 1'b0;
    mode_pwm = 4'hF;
    repeat (6) @(posedge clk_in);
    #2;
    arst_n_in = 1'b1;
    t_reset_values();
    t_reg_access();
    t_direct_and_mode();
    t_external();
    t_ramp(8'h02, 1'b0);
    t_ramp(8'h00, 1'b1);
    give_verdict();
  end

  // The run needs about 4200 cycles; nearly five times that means a hang.
  initial
  begin
    repeat (20000) @(posedge clk_in);
    err_count++;
    give_verdict();
  end
endmodule : tb_led_pwm_dimming_control
